/* File: rtl/gpp_defines.vh */
// Register offsets, field masks and reset values of the general purpose port block
`ifndef GPP_DEFINES_VH
`define GPP_DEFINES_VH

// ----------------------------------------------------------------
// Address layout: one 32-byte window per port, then global words
// ----------------------------------------------------------------
`define GPP_PORT_SEL_HI   7
`define GPP_PORT_SEL_LO   5
`define GPP_REG_SEL_HI    4
`define GPP_REG_SEL_LO    2
`define GPP_NUM_PORTS     5
`define GPP_GLOBAL_SEL    3'h5

// Per-port register indexes (byte offset is index times four)
`define GPP_REG_DOUT      3'h0
`define GPP_REG_DIR       3'h1
`define GPP_REG_PULL      3'h2
`define GPP_REG_ODRAIN    3'h3
`define GPP_REG_IEN       3'h4
`define GPP_REG_LEVEL     3'h5

// Global register indexes inside the global window
`define GPP_REG_ISTAT     3'h0
`define GPP_REG_IMASK     3'h1

// ----------------------------------------------------------------
// Field masks and reset values
// ----------------------------------------------------------------
`define GPP_IMPL_FULL     8'hFF
`define GPP_IMPL_PORT3    8'h1F
`define GPP_OONLY_PORT1   8'h20
`define GPP_OONLY_NONE    8'h00
`define GPP_RST_DOUT      8'h00
`define GPP_RST_DIR       8'h00
`define GPP_RST_PULL      8'h00
`define GPP_RST_ODRAIN    8'h00
`define GPP_RST_IEN       8'h00
`define GPP_RST_ISTAT     24'h000000
`define GPP_RST_IMASK     24'h000000

`endif

/* File: rtl/gpp_port.v */
// One eight-bit general purpose port: pin synchroniser, drive control, change events
`timescale 1ns/1ps
`default_nettype none

module gpp_port #(
  parameter [7:0] IMPL  = 8'hFF,
  parameter [7:0] OONLY = 8'h00,
  parameter       IRQC  = 1
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Configuration from the register file
  input  wire [7:0] dout,
  input  wire [7:0] dir,
  input  wire [7:0] pull,
  input  wire [7:0] odrain,
  input  wire [7:0] ien,
  // Pins
  input  wire [7:0] pin_i,
  output reg  [7:0] pin_o,
  output reg  [7:0] pin_oe_n,
  output reg  [7:0] pin_pu,
  // State seen by software
  output wire [7:0] level,
  output wire [7:0] evt
);

  reg  [7:0] sync1_q;
  reg  [7:0] sync2_q;
  reg  [7:0] last_q;
  wire [7:0] drive;
  wire [7:0] en;
  wire [7:0] irq_bits;

  // ----------------------------------------------------------------
  // Input path
  // ----------------------------------------------------------------
  // Two stages before use; the third holds the previous level for edges
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      last_q  <= 8'h00;
    end else begin
      sync1_q <= pin_i & IMPL;
      sync2_q <= sync1_q;
      last_q  <= sync2_q;
    end
  end

  // Output-only bits read back what they drive; levels always readable
  assign level = ((sync2_q & ~OONLY) | (dout & OONLY)) & IMPL;

  // A change on an enabled input is an event; masked pins stay silent
  assign irq_bits = IRQC ? (IMPL & ~OONLY) : 8'h00;
  assign evt      = (sync2_q ^ last_q) & ien & irq_bits;

  // ----------------------------------------------------------------
  // Output path
  // ----------------------------------------------------------------
  // Each bit chooses direction and drive type alone
  assign drive = (dir | OONLY) & IMPL;
  // Open drain only sinks: enable when low, release when high
  assign en    = drive & (~odrain | ~dout);

  // Registered so pins never glitch on decode changes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o    <= 8'h00;
      pin_oe_n <= ~OONLY;
      pin_pu   <= 8'h00;
    end else begin
      pin_o    <= dout & en;
      pin_oe_n <= ~en;
      pin_pu   <= pull & IMPL;
    end
  end

endmodule // gpp_port

`default_nettype wire

/* File: rtl/gpp_top.v */
// General purpose port block with APB register access and one interrupt line
`timescale 1ns/1ps
`default_nettype none
`include "gpp_defines.vh"

module gpp_top (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Interrupt
  output wire        irq,
  // Port zero
  input  wire [7:0]  port_zero_pins_i,
  output wire [7:0]  port_zero_pins_o,
  output wire [7:0]  port_zero_pins_oe_n,
  output wire [7:0]  port_zero_pins_pu,
  // Port one, bit 0
  input  wire        port_one_bit0_pin_i,
  output wire        port_one_bit0_pin_o,
  output wire        port_one_bit0_pin_oe_n,
  output wire        port_one_bit0_pin_pu,
  // Port one, bits 1 to 4
  input  wire [3:0]  port_one_bits1to4_pins_i,
  output wire [3:0]  port_one_bits1to4_pins_o,
  output wire [3:0]  port_one_bits1to4_pins_oe_n,
  output wire [3:0]  port_one_bits1to4_pins_pu,
  // Port one, bit 5 (drives only)
  output wire        port_one_output_only_pin_o,
  output wire        port_one_output_only_pin_oe_n,
  output wire        port_one_output_only_pin_pu,
  // Port one, bits 6 and 7
  input  wire [1:0]  port_one_bits6to7_pins_i,
  output wire [1:0]  port_one_bits6to7_pins_o,
  output wire [1:0]  port_one_bits6to7_pins_oe_n,
  output wire [1:0]  port_one_bits6to7_pins_pu,
  // Port two
  input  wire [7:0]  port_two_pins_i,
  output wire [7:0]  port_two_pins_o,
  output wire [7:0]  port_two_pins_oe_n,
  output wire [7:0]  port_two_pins_pu,
  // Port three, bits 0 to 3
  input  wire [3:0]  port_three_low_pins_i,
  output wire [3:0]  port_three_low_pins_o,
  output wire [3:0]  port_three_low_pins_oe_n,
  output wire [3:0]  port_three_low_pins_pu,
  // Port three, bit 4
  input  wire        port_three_bit4_pin_i,
  output wire        port_three_bit4_pin_o,
  output wire        port_three_bit4_pin_oe_n,
  output wire        port_three_bit4_pin_pu,
  // Port four
  input  wire [7:0]  port_four_pins_i,
  output wire [7:0]  port_four_pins_o,
  output wire [7:0]  port_four_pins_oe_n,
  output wire [7:0]  port_four_pins_pu
);

  // ----------------------------------------------------------------
  // Per-port feature masks
  // ----------------------------------------------------------------
  // Bits that exist on a port
  function [7:0] impl_m;
    input [2:0] p;
    begin
      impl_m = (p == 3'd3) ? `GPP_IMPL_PORT3 : `GPP_IMPL_FULL;
    end
  endfunction

  // Bits that only drive
  function [7:0] oonly_m;
    input [2:0] p;
    begin
      oonly_m = (p == 3'd1) ? `GPP_OONLY_PORT1 : `GPP_OONLY_NONE;
    end
  endfunction

  // Bits that may raise interrupts
  function [7:0] irq_m;
    input [2:0] p;
    begin
      if (p == 3'd0 || p == 3'd1 || p == 3'd4) begin
        irq_m = impl_m(p) & ~oonly_m(p);
      end else begin
        irq_m = 8'h00;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0]  dout_q   [0:4];
  reg  [7:0]  dir_q    [0:4];
  reg  [7:0]  pull_q   [0:4];
  reg  [7:0]  odrain_q [0:4];
  reg  [7:0]  ien_q    [0:4];
  reg  [23:0] istat_q;
  reg  [23:0] imask_q;
  reg  [31:0] prdata_q;
  reg  [31:0] rd_d;
  reg         pready_q;
  reg         pslverr_q;
  reg         err_d;
  reg         irq_q;
  reg  [23:0] istat_d;
  integer     k;

  wire [39:0] pin_i_all;
  wire [39:0] pin_o_all;
  wire [39:0] pin_oe_n_all;
  wire [39:0] pin_pu_all;
  wire [39:0] level_all;
  wire [39:0] evt_all;

  wire [2:0]  port_sel = paddr[`GPP_PORT_SEL_HI:`GPP_PORT_SEL_LO];
  wire [2:0]  reg_sel  = paddr[`GPP_REG_SEL_HI:`GPP_REG_SEL_LO];
  wire        is_port  = (port_sel < `GPP_NUM_PORTS);
  wire        is_glob  = (port_sel == `GPP_GLOBAL_SEL);
  wire        access   = psel & penable & pready_q;
  wire        wr_en    = access & pwrite & ~pslverr_q;
  wire        rd_en    = access & ~pwrite & ~pslverr_q;
  wire [7:0]  wdat     = pwdata[7:0];
  wire [7:0]  im       = impl_m(port_sel);
  wire [7:0]  om       = oonly_m(port_sel);

  // ----------------------------------------------------------------
  // Pin packing: bit 8*p+b is port p, bit b
  // ----------------------------------------------------------------
  // Absent inputs are tied low; the port masks them anyway
  assign pin_i_all = {port_four_pins_i,
                      3'b000, port_three_bit4_pin_i, port_three_low_pins_i,
                      port_two_pins_i,
                      port_one_bits6to7_pins_i, 1'b0, port_one_bits1to4_pins_i,
                      port_one_bit0_pin_i,
                      port_zero_pins_i};

  // ----------------------------------------------------------------
  // Port instances
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `GPP_NUM_PORTS; g = g + 1) begin : g_port
      gpp_port #(
        .IMPL  ((g == 3) ? `GPP_IMPL_PORT3 : `GPP_IMPL_FULL),
        .OONLY ((g == 1) ? `GPP_OONLY_PORT1 : `GPP_OONLY_NONE),
        .IRQC  ((g == 0) || (g == 1) || (g == 4))
      ) u_port (
        .clk      (pclk),
        .rst_n    (presetn),
        .dout     (dout_q[g]),
        .dir      (dir_q[g]),
        .pull     (pull_q[g]),
        .odrain   (odrain_q[g]),
        .ien      (ien_q[g]),
        .pin_i    (pin_i_all[8*g+7:8*g]),
        .pin_o    (pin_o_all[8*g+7:8*g]),
        .pin_oe_n (pin_oe_n_all[8*g+7:8*g]),
        .pin_pu   (pin_pu_all[8*g+7:8*g]),
        .level    (level_all[8*g+7:8*g]),
        .evt      (evt_all[8*g+7:8*g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Writes are masked so absent and fixed bits keep their values
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (k = 0; k < `GPP_NUM_PORTS; k = k + 1) begin
        dout_q[k]   <= `GPP_RST_DOUT;
        dir_q[k]    <= `GPP_RST_DIR;
        pull_q[k]   <= `GPP_RST_PULL;
        odrain_q[k] <= `GPP_RST_ODRAIN;
        ien_q[k]    <= `GPP_RST_IEN;
      end
      imask_q <= `GPP_RST_IMASK;
    end else if (wr_en && is_port) begin
      case (reg_sel)
        `GPP_REG_DOUT:   dout_q[port_sel]   <= wdat & im;
        `GPP_REG_DIR:    dir_q[port_sel]    <= wdat & im & ~om;
        `GPP_REG_PULL:   pull_q[port_sel]   <= wdat & im;
        `GPP_REG_ODRAIN: odrain_q[port_sel] <= wdat & im;
        `GPP_REG_IEN:    ien_q[port_sel]    <= wdat & irq_m(port_sel);
        default: begin
        end
      endcase
    end else if (wr_en && is_glob && reg_sel == `GPP_REG_IMASK) begin
      imask_q <= pwdata[23:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  // Port zero, one and four events; a new event beats a read clear
  always @* begin
    istat_d = istat_q;
    if (rd_en && is_glob && reg_sel == `GPP_REG_ISTAT) begin
      istat_d = 24'h000000;
    end
    istat_d = istat_d | {evt_all[39:32], evt_all[15:8], evt_all[7:0]};
  end

  // Level output registered so it changes on clock edges only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= `GPP_RST_ISTAT;
      irq_q   <= 1'b0;
    end else begin
      istat_q <= istat_d;
      irq_q   <= |(istat_d & imask_q);
    end
  end

  // ----------------------------------------------------------------
  // APB read decode
  // ----------------------------------------------------------------
  // Unmapped words read zero and report an error
  always @* begin
    rd_d  = 32'h00000000;
    err_d = 1'b0;
    if (is_port) begin
      case (reg_sel)
        `GPP_REG_DOUT:   rd_d[7:0] = dout_q[port_sel];
        `GPP_REG_DIR:    rd_d[7:0] = dir_q[port_sel] | om;
        `GPP_REG_PULL:   rd_d[7:0] = pull_q[port_sel];
        `GPP_REG_ODRAIN: rd_d[7:0] = odrain_q[port_sel];
        `GPP_REG_IEN:    rd_d[7:0] = ien_q[port_sel];
        `GPP_REG_LEVEL:  rd_d[7:0] = level_all[8*port_sel +: 8];
        default:         err_d     = 1'b1;
      endcase
      if (pwrite && reg_sel == `GPP_REG_LEVEL) begin
        err_d = 1'b1;
      end
    end else if (is_glob) begin
      case (reg_sel)
        `GPP_REG_ISTAT:  rd_d[23:0] = istat_q;
        `GPP_REG_IMASK:  rd_d[23:0] = imask_q;
        default:         err_d      = 1'b1;
      endcase
      if (pwrite && reg_sel == `GPP_REG_ISTAT) begin
        err_d = 1'b1;
      end
    end else begin
      err_d = 1'b1;
    end
  end

  // No wait state: answer is captured in the setup cycle, shown in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & err_d;
      prdata_q  <= (psel & ~penable & ~pwrite) ? rd_d : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

  assign port_zero_pins_o              = pin_o_all[7:0];
  assign port_zero_pins_oe_n           = pin_oe_n_all[7:0];
  assign port_zero_pins_pu             = pin_pu_all[7:0];
  assign port_one_bit0_pin_o           = pin_o_all[8];
  assign port_one_bit0_pin_oe_n        = pin_oe_n_all[8];
  assign port_one_bit0_pin_pu          = pin_pu_all[8];
  assign port_one_bits1to4_pins_o      = pin_o_all[12:9];
  assign port_one_bits1to4_pins_oe_n   = pin_oe_n_all[12:9];
  assign port_one_bits1to4_pins_pu     = pin_pu_all[12:9];
  assign port_one_output_only_pin_o    = pin_o_all[13];
  assign port_one_output_only_pin_oe_n = pin_oe_n_all[13];
  assign port_one_output_only_pin_pu   = pin_pu_all[13];
  assign port_one_bits6to7_pins_o      = pin_o_all[15:14];
  assign port_one_bits6to7_pins_oe_n   = pin_oe_n_all[15:14];
  assign port_one_bits6to7_pins_pu     = pin_pu_all[15:14];
  assign port_two_pins_o               = pin_o_all[23:16];
  assign port_two_pins_oe_n            = pin_oe_n_all[23:16];
  assign port_two_pins_pu              = pin_pu_all[23:16];
  assign port_three_low_pins_o         = pin_o_all[27:24];
  assign port_three_low_pins_oe_n      = pin_oe_n_all[27:24];
  assign port_three_low_pins_pu        = pin_pu_all[27:24];
  assign port_three_bit4_pin_o         = pin_o_all[28];
  assign port_three_bit4_pin_oe_n      = pin_oe_n_all[28];
  assign port_three_bit4_pin_pu        = pin_pu_all[28];
  assign port_four_pins_o              = pin_o_all[39:32];
  assign port_four_pins_oe_n           = pin_oe_n_all[39:32];
  assign port_four_pins_pu             = pin_pu_all[39:32];

endmodule // gpp_top

`default_nettype wire

/* File: test/gpp_chk.sv */
// Concurrent checks on the APB, pin and interrupt outputs of the port block
`timescale 1ns/1ps
`default_nettype none

module gpp_chk (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Interrupt and a few pin groups
  input wire logic        irq,
  input wire logic [7:0]  port_zero_pins_o,
  input wire logic [7:0]  port_zero_pins_oe_n,
  input wire logic [7:0]  port_two_pins_o,
  input wire logic        port_one_output_only_pin_o,
  input wire logic        port_one_output_only_pin_oe_n
);
  logic wr_c;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Write commit flag, so $past below sees one plain signal
  assign wr_c = psel && penable && pready && pwrite;

  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr;
    psel && penable && pready && pwrite;
  endsequence

  a_ready_after_setup:
    assert property (s_setup |=> pready) else $error("ready missing after setup");
  a_ready_in_access:
    assert property (pready |-> psel && penable) else $error("ready outside access");
  a_error_with_ready:
    assert property (pslverr |-> pready) else $error("error without ready");
  a_rdata_idle_zero:
    assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside read access");

  // ----------------------------------------------------------------
  // Pins and interrupt
  // ----------------------------------------------------------------
  a_oonly_reset_low:
    assert property ($rose(presetn) |-> !port_one_output_only_pin_oe_n
      && !port_one_output_only_pin_o) else $error("output-only pin not low after reset");
  a_released_out_low:
    assert property ((port_zero_pins_o & port_zero_pins_oe_n) == 8'h00)
      else $error("released pin shows a value");
  a_out_change_cause:
    assert property ($changed(port_two_pins_o) |-> $past(wr_c, 2))
      else $error("pin output changed with no write");
  a_mask_clear_irq:
    assert property (s_wr ##0 (paddr == 8'hA4 && pwdata[23:0] == 24'h0) |-> ##2 !irq)
      else $error("irq stays with all masked");
endmodule // gpp_chk

bind gpp_top gpp_chk i_gpp_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .irq, .port_zero_pins_o, .port_zero_pins_oe_n, .port_two_pins_o,
  .port_one_output_only_pin_o, .port_one_output_only_pin_oe_n
);

`default_nettype wire

/* File: test/gpp_pin_model.sv */
// Board side of the port pins: works out the level on every wire
`timescale 1ns/1ps
`default_nettype none

module gpp_pin_model (
  // Clock
  input  wire logic        pclk,
  // Block side of each pin
  input  wire logic [39:0] pin_o,
  input  wire logic [39:0] pin_oe_n,
  input  wire logic [39:0] pin_pu,
  // Board drivers
  input  wire logic [39:0] ext_val,
  input  wire logic [39:0] ext_en,
  // Wire levels
  output logic      [39:0] lvl
);
  logic [39:0] last_q = 40'h0;

  // Block drive wins; a floating wire holds nothing, so it toggles each cycle
  assign lvl = (~pin_oe_n & pin_o) | (pin_oe_n & ext_en & ext_val)
             | (pin_oe_n & ~ext_en & pin_pu) | (pin_oe_n & ~ext_en & ~pin_pu & ~last_q);

  // Previous level, only used for floating wires
  always @(posedge pclk) begin
    last_q <= lvl;
  end
endmodule // gpp_pin_model

`default_nettype wire

/* File: test/test_gpp_top.sv */
// Self-checking bench for the general purpose port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) chk(n, e, g)

module test_gpp_top;
  typedef struct {logic [7:0] a; logic [31:0] w, r, e;} gpp_row_t;
  typedef struct {int b; logic [31:0] st; logic q;} gpp_evt_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rd_e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_d;
  wire logic [39:0] po, pe, pu, lvl;
  logic [39:0] ext_val;
  int          fail_count, samples_checked, cyc;
  // Address, write value, reset value, read-back value
  gpp_row_t rows[14] = '{
    '{8'h00, 32'hA5, 32'h00, 32'hA5},
    '{8'h0C, 32'h03, 32'h00, 32'h03},
    '{8'h08, 32'hF1, 32'h00, 32'hF1},
    '{8'h24, 32'h00, 32'h20, 32'h20},
    '{8'h6C, 32'hFF, 32'h00, 32'h1F},
    '{8'h50, 32'hFF, 32'h00, 32'h00},
    '{8'h70, 32'hFF, 32'h00, 32'h00},
    '{8'h44, 32'hFF, 32'h00, 32'hFF},
    '{8'h40, 32'h5A, 32'h00, 32'h5A},
    '{8'h30, 32'h40, 32'h00, 32'h40},
    '{8'h10, 32'h01, 32'h00, 32'h01},
    '{8'h90, 32'h80, 32'h00, 32'h80},
    '{8'hA4, 32'h7FFFFF, 32'h00, 32'h7FFFFF},
    '{8'h04, 32'h0F, 32'h00, 32'h0F}};
  // Pin bit, expected status, expected irq
  gpp_evt_t evts[7] = '{
    '{1, 32'h0, 1'b0}, '{0, 32'h1, 1'b1},
    '{14, 32'h4000, 1'b1},
    '{16, 32'h0, 1'b0}, '{24, 32'h0, 1'b0},
    '{39, 32'h800000, 1'b0}, '{38, 32'h0, 1'b0}};

  // ----------------------------------------------------------------
  // Design and board
  // ----------------------------------------------------------------
  // Bits 31:29 stand for the absent pins of port three
  assign po[31:29] = 3'h0;
  assign pe[31:29] = 3'h7;
  assign pu[31:29] = 3'h0;

  gpp_top i_gpp_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq),
    .port_zero_pins_i(lvl[7:0]), .port_zero_pins_o(po[7:0]),
    .port_zero_pins_oe_n(pe[7:0]), .port_zero_pins_pu(pu[7:0]),
    .port_one_bit0_pin_i(lvl[8]), .port_one_bit0_pin_o(po[8]),
    .port_one_bit0_pin_oe_n(pe[8]), .port_one_bit0_pin_pu(pu[8]),
    .port_one_bits1to4_pins_i(lvl[12:9]), .port_one_bits1to4_pins_o(po[12:9]),
    .port_one_bits1to4_pins_oe_n(pe[12:9]), .port_one_bits1to4_pins_pu(pu[12:9]),
    .port_one_output_only_pin_o(po[13]), .port_one_output_only_pin_oe_n(pe[13]),
    .port_one_output_only_pin_pu(pu[13]),
    .port_one_bits6to7_pins_i(lvl[15:14]), .port_one_bits6to7_pins_o(po[15:14]),
    .port_one_bits6to7_pins_oe_n(pe[15:14]), .port_one_bits6to7_pins_pu(pu[15:14]),
    .port_two_pins_i(lvl[23:16]), .port_two_pins_o(po[23:16]),
    .port_two_pins_oe_n(pe[23:16]), .port_two_pins_pu(pu[23:16]),
    .port_three_low_pins_i(lvl[27:24]), .port_three_low_pins_o(po[27:24]),
    .port_three_low_pins_oe_n(pe[27:24]), .port_three_low_pins_pu(pu[27:24]),
    .port_three_bit4_pin_i(lvl[28]), .port_three_bit4_pin_o(po[28]),
    .port_three_bit4_pin_oe_n(pe[28]), .port_three_bit4_pin_pu(pu[28]),
    .port_four_pins_i(lvl[39:32]), .port_four_pins_o(po[39:32]),
    .port_four_pins_oe_n(pe[39:32]), .port_four_pins_pu(pu[39:32]));

  gpp_pin_model i_gpp_pin_model (
    .pclk(pclk), .pin_o(po), .pin_oe_n(pe), .pin_pu(pu), .ext_val(ext_val),
    .ext_en({40{1'b1}}), .lvl(lvl));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // One transfer; the request holds until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK("ready wait", 32'd1, n);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    `CHK("write error", 1'b0, rd_e);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // The whole run needs well under 2000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; ext_val = 40'h0;
    fail_count = 0; samples_checked = 0; cyc = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK("reset drive", 32'hFFFFDFFF, pe[31:0]);
    `CHK("reset out", 32'h0, po[31:0]);
    `CHK("reset p4 drive", 32'hFF, pe[39:32]);
    `CHK("reset p4 out", 32'h0, po[39:32]);
    `CHK("reset pull", 32'h0, pu[31:0] | pu[39:32]);
    foreach (rows[i]) begin
      rd(rows[i].a);
      `CHK("reset value", rows[i].r, rd_d);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      `CHK("read back", rows[i].e, rd_d);
    end
    // Mixed push-pull, open-drain and input pins on port zero
    ext_val[7:0] <= 8'h30;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    `CHK("p0 out", 8'h04, po[7:0]);
    `CHK("p0 drive", 8'hF1, pe[7:0]);
    `CHK("p0 pull", 8'hF1, pu[7:0]);
    `CHK("p2 out", 8'h5A, po[23:16]);
    `CHK("p2 drive", 8'h00, pe[23:16]);
    rd(8'h14);
    `CHK("p0 level", 32'h34, rd_d);
    wr(8'h20, 32'h20);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    `CHK("oonly out", 1'b1, po[13]);
    `CHK("oonly drive", 1'b0, pe[13]);
    // Refused accesses: level write, status write, unmapped read
    apb(1'b1, 8'h14, 32'hFF);
    `CHK("level write err", 1'b1, rd_e);
    apb(1'b1, 8'hA0, 32'hFF);
    `CHK("status write err", 1'b1, rd_e);
    apb(1'b0, 8'hC0, 32'h0);
    `CHK("unmapped err", 1'b1, rd_e);
    `CHK("unmapped data", 32'h0, rd_d);
    // Interrupt sources, one pin change at a time
    wr(8'h04, 32'h0);
    repeat (4) @(posedge pclk);
    rd(8'hA0);
    `CHK("status idle", 32'h0, rd_d);
    foreach (evts[i]) begin
      ext_val[evts[i].b] <= ~ext_val[evts[i].b];
      repeat (8) @(posedge pclk);
      `CHK("irq level", evts[i].q, irq);
      rd(8'hA0);
      `CHK("status", evts[i].st, rd_d);
      repeat (3) @(posedge pclk);
      `CHK("irq cleared", 1'b0, irq);
    end
    // Masking a pending event drops the line but keeps the status
    ext_val[0] <= 1'b0;
    repeat (8) @(posedge pclk);
    `CHK("irq pending", 1'b1, irq);
    wr(8'hA4, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK("irq masked", 1'b0, irq);
    rd(8'hA0);
    `CHK("status kept", 32'h1, rd_d);
    report_and_stop();
  end
endmodule // test_gpp_top

`default_nettype wire
